// *** radio_interrupt_status_enable.sv ***
`timescale 1ns/1ps
`include "radio_irq_map.svh"
// Summary of operation
// - sync bit set on sync, cleared packet end
// - preamble bit set, cleared on sync/timeout
// - invalid preamble bit sets, then self-clears
// - strength bit follows level above threshold
// - wake-up bit set on timer expiry
// - low battery latched; interrupts once enabled
// - ready after settle time, until idle
// - power-on bit set on reset event
// - enabled rising bit drives request low
// - status read releases request, clears enabled
// - disabled bits untouched by status read
// - second status register read-only, reset to zero
// - enable one bits 7..3 fifo/external enables
// - enable one bits 2..0 packet enables
// - enable two holds one enable per bit
// - first status behaves alike under enable one
module radio_interrupt_status_enable #(
	parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire radio_irq_pkg::reg_req_type reg_i,
	input wire radio_irq_pkg::radio_event_type radio_ev_i,
	input wire radio_irq_pkg::fifo_event_type fifo_ev_i,
	input wire logic strength_above_i,
	input wire logic xtal_on_i,
	output logic [7:0] rdata_o,
	output logic interrupt_request_low_o
);
	import radio_irq_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] status_one_ff; // fifo and packet events
	logic [7:0] status_two_ff; // radio events
	logic [7:0] enable_one_ff; // masks for status one
	logic [7:0] enable_two_ff; // masks for status two
	logic strength_q_ff; // last strength level, for edges
	logic [15:0] settle_cnt_ff; // crystal settle counter
	logic [7:0] rdata_ff; // registered read answer
	logic irq_low_ff; // interrupt request, active low
	logic [7:0] nxt_status_one;
	logic [7:0] nxt_status_two;
	logic [7:0] nxt_enable_one;
	logic [7:0] nxt_enable_two;
	logic [7:0] set_two; // set pulses per bit
	logic [7:0] clr_two; // hardware clear per bit
	logic rd_one; // read of status one
	logic rd_two; // read of status two
	logic ready_done; // settle time just elapsed

	// ----------------------------------------------------------------
	// status update, shared by both status registers
	// ----------------------------------------------------------------
	// enabled bits hold until read; disabled bits follow hardware;
	// a set in the clearing cycle wins so no event is lost
	function automatic logic [7:0] next_status(input logic [7:0] cur, input logic [7:0] en,
		input logic [7:0] set, input logic [7:0] hw_clr, input logic rd);
		next_status = set | (cur & ~((en & {8{rd}}) | (~en & hw_clr)));
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign rd_one = reg_i.rd && reg_i.addr == `EVENT_STATUS_ONE_ADDR;
	assign rd_two = reg_i.rd && reg_i.addr == `EVENT_STATUS_TWO_ADDR;

	// settle count ends while crystal, tx or rx stays on
	assign ready_done = xtal_on_i && settle_cnt_ff == 16'(SETTLE_CYCLES - 1);

	// ----------------------------------------------------------------
	// set and clear sources of status two
	// ----------------------------------------------------------------
	always_comb begin
		// masked strength follows the level; an enabled one sets on a rising
		// edge only, otherwise a read could never release the request
		set_two = {radio_ev_i.sync_found, radio_ev_i.preamble_found,
			radio_ev_i.preamble_missing,
			strength_above_i && (!strength_q_ff || !enable_two_ff[`STRENGTH_BIT]),
			radio_ev_i.wakeup_expired, radio_ev_i.battery_low, ready_done,
			radio_ev_i.power_on_event};
		clr_two = 8'h00;
		clr_two[`SYNC_BIT] = radio_ev_i.packet_done;
		clr_two[`PREAMBLE_BIT] = radio_ev_i.sync_found || radio_ev_i.sync_timeout;
		clr_two[`INVALID_BIT] = 1'b1; // self-clearing pulse
		clr_two[`STRENGTH_BIT] = !strength_above_i;
		clr_two[`WAKEUP_BIT] = 1'b1; // event only, not status
		clr_two[`BATTERY_BIT] = 1'b0; // latched even when masked
		clr_two[`READY_BIT] = !xtal_on_i; // back to idle
		clr_two[`POWER_ON_BIT] = 1'b0;
	end

	// ----------------------------------------------------------------
	// next values of the registers
	// ----------------------------------------------------------------
	always_comb begin
		nxt_status_two = next_status(status_two_ff, enable_two_ff, set_two, clr_two,
			rd_two);
		nxt_status_one = next_status(status_one_ff, enable_one_ff, fifo_ev_i.set,
			fifo_ev_i.clr, rd_one);
		nxt_enable_one = enable_one_ff;
		nxt_enable_two = enable_two_ff;
		// status registers ignore writes; only enables take data
		if (reg_i.wr && reg_i.addr == `EVENT_ENABLE_ONE_ADDR) begin
			nxt_enable_one = reg_i.wdata;
		end
		if (reg_i.wr && reg_i.addr == `EVENT_ENABLE_TWO_ADDR) begin
			nxt_enable_two = reg_i.wdata;
		end
	end

	// ----------------------------------------------------------------
	// status registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_one_ff <= `STATUS_RESET;
			status_two_ff <= `STATUS_RESET;
		end else begin
			status_one_ff <= nxt_status_one;
			status_two_ff <= nxt_status_two;
		end
	end

	// ----------------------------------------------------------------
	// enable registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable_one_ff <= `ENABLE_RESET;
			enable_two_ff <= `ENABLE_RESET;
		end else begin
			enable_one_ff <= nxt_enable_one;
			enable_two_ff <= nxt_enable_two;
		end
	end

	// ----------------------------------------------------------------
	// strength edge and crystal settle timing
	// ----------------------------------------------------------------
	// counter saturates so ready rises exactly once per power-up
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strength_q_ff <= 1'b0;
			settle_cnt_ff <= 16'h0000;
		end else begin
			strength_q_ff <= strength_above_i;
			if (!xtal_on_i) begin
				settle_cnt_ff <= 16'h0000; // idle restarts the wait
			end else if (settle_cnt_ff != 16'(SETTLE_CYCLES)) begin
				settle_cnt_ff <= settle_cnt_ff + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// read answer, one cycle after the strobe; shows pre-clear value
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_ff <= `READ_UNMAPPED;
		end else if (reg_i.rd) begin
			unique case (reg_i.addr)
				`EVENT_STATUS_ONE_ADDR: rdata_ff <= status_one_ff;
				`EVENT_STATUS_TWO_ADDR: rdata_ff <= status_two_ff;
				`EVENT_ENABLE_ONE_ADDR: rdata_ff <= enable_one_ff;
				`EVENT_ENABLE_TWO_ADDR: rdata_ff <= enable_two_ff;
				default: rdata_ff <= `READ_UNMAPPED; // unmapped offsets read zero
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt request, low while any enabled bit is pending
	// ----------------------------------------------------------------
	// built from next values so the pin tracks the registers exactly
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_low_ff <= 1'b1;
		end else begin
			irq_low_ff <= ~|((nxt_status_one & nxt_enable_one) |
				(nxt_status_two & nxt_enable_two));
		end
	end

	assign rdata_o = rdata_ff;
	assign interrupt_request_low_o = irq_low_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence enabled_sync_s;
		radio_ev_i.sync_found && enable_two_ff[`SYNC_BIT] && !rd_two &&
			!(reg_i.wr && reg_i.addr == `EVENT_ENABLE_TWO_ADDR);
	endsequence

	sequence clean_status_read_s;
		rd_two && set_two == 8'h00;
	endsequence

	sync_set_a: assert property (radio_ev_i.sync_found |=> status_two_ff[`SYNC_BIT])
		else $error("sync bit not set");
	sync_clear_a: assert property (radio_ev_i.packet_done && !radio_ev_i.sync_found &&
		!enable_two_ff[`SYNC_BIT] |=> !status_two_ff[`SYNC_BIT])
		else $error("sync bit not cleared at packet end");
	preamble_clear_a: assert property ((radio_ev_i.sync_found || radio_ev_i.sync_timeout) &&
		!radio_ev_i.preamble_found && !enable_two_ff[`PREAMBLE_BIT]
		|=> !status_two_ff[`PREAMBLE_BIT])
		else $error("preamble bit not cleared");
	invalid_pulse_a: assert property (radio_ev_i.preamble_missing && !enable_two_ff[`INVALID_BIT]
		##1 !radio_ev_i.preamble_missing && !enable_two_ff[`INVALID_BIT]
		|-> status_two_ff[`INVALID_BIT] ##1 !status_two_ff[`INVALID_BIT])
		else $error("invalid preamble bit did not self-clear");
	strength_follow_a: assert property ((!enable_two_ff[`STRENGTH_BIT] && strength_above_i)[*2]
		|=> status_two_ff[`STRENGTH_BIT])
		else $error("strength bit not following level");
	wakeup_set_a: assert property (radio_ev_i.wakeup_expired |=> status_two_ff[`WAKEUP_BIT])
		else $error("wake-up bit not set");
	battery_hold_a: assert property (status_two_ff[`BATTERY_BIT] && !enable_two_ff[`BATTERY_BIT]
		|=> status_two_ff[`BATTERY_BIT])
		else $error("masked low battery event lost");
	battery_late_a: assert property (status_two_ff[`BATTERY_BIT] && $rose(enable_two_ff[`BATTERY_BIT])
		|-> !interrupt_request_low_o)
		else $error("late enable gave no request");
	ready_timing_a: assert property ($rose(status_two_ff[`READY_BIT]) && !$past(status_two_ff[`READY_BIT])
		|-> $past(settle_cnt_ff) == 16'(SETTLE_CYCLES - 1) && $past(xtal_on_i))
		else $error("ready rose before settle time");
	ready_idle_a: assert property (!xtal_on_i && !enable_two_ff[`READY_BIT]
		|=> !status_two_ff[`READY_BIT])
		else $error("ready stayed high in idle");
	power_on_a: assert property (radio_ev_i.power_on_event |=> status_two_ff[`POWER_ON_BIT])
		else $error("power-on bit not set");
	request_low_a: assert property (enabled_sync_s |=> !interrupt_request_low_o)
		else $error("enabled event did not pull request low");
	read_clear_a: assert property (clean_status_read_s
		|=> (status_two_ff & $past(enable_two_ff)) == 8'h00)
		else $error("read left enabled bits set");
	read_keep_a: assert property (rd_two && !enable_two_ff[`BATTERY_BIT] && status_two_ff[`BATTERY_BIT]
		|=> status_two_ff[`BATTERY_BIT])
		else $error("read cleared a masked bit");
	enable_write_a: assert property (reg_i.wr && reg_i.addr == `EVENT_ENABLE_ONE_ADDR
		|=> enable_one_ff == $past(reg_i.wdata))
		else $error("enable one write not taken");
	status_one_read_a: assert property (rd_one && fifo_ev_i.set == 8'h00
		|=> (status_one_ff & $past(enable_one_ff)) == 8'h00)
		else $error("status one read left enabled bits");
	request_level_a: assert property (interrupt_request_low_o ==
		~|((status_one_ff & enable_one_ff) | (status_two_ff & enable_two_ff)))
		else $error("request level disagrees with pending bits");

endmodule

// *** radio_irq_map.svh ***
`ifndef RADIO_IRQ_MAP_SVH
`define RADIO_IRQ_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EVENT_STATUS_ONE_ADDR 8'h03
`define EVENT_STATUS_TWO_ADDR 8'h04
`define EVENT_ENABLE_ONE_ADDR 8'h05
`define EVENT_ENABLE_TWO_ADDR 8'h06

// ----------------------------------------------------------------
// reset values (status powers up undefined; zero is used here)
// ----------------------------------------------------------------
`define STATUS_RESET 8'h00
`define ENABLE_RESET 8'h00
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// bit positions of the second status register
// ----------------------------------------------------------------
`define SYNC_BIT 7
`define PREAMBLE_BIT 6
`define INVALID_BIT 5
`define STRENGTH_BIT 4
`define WAKEUP_BIT 3
`define BATTERY_BIT 2
`define READY_BIT 1
`define POWER_ON_BIT 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 40
`define SETTLE_US 1
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)

`endif

// *** radio_irq_pkg.sv ***
package radio_irq_pkg;

	// ----------------------------------------------------------------
	// register access request from the serial front end
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rd; // one-cycle read strobe
		logic wr; // one-cycle write strobe
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write data
	} reg_req_type;

	// ----------------------------------------------------------------
	// one-cycle radio events feeding the second status register
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sync_found; // sync word recognised
		logic packet_done; // reception of current packet finished
		logic preamble_found; // valid preamble seen
		logic sync_timeout; // wait for sync ran out
		logic preamble_missing; // no preamble in time after rx enable
		logic wakeup_expired; // wake-up interval elapsed
		logic battery_low; // low battery detected
		logic power_on_event; // power-on reset above threshold
	} radio_event_type;

	// ----------------------------------------------------------------
	// fifo and packet events feeding the first status register
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] set; // per-bit set pulses
		logic [7:0] clr; // per-bit hardware clear pulses
	} fifo_event_type;

endpackage

// *** host_model.sv ***
`timescale 1ns/1ps
// --------------------
// host side register access
// --------------------
module host_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rdata_i,
	output radio_irq_pkg::reg_req_type req_o
);
	import radio_irq_pkg::*;
	// bus idle with both strobes low
	initial begin
		req_o = '0;
	end
	// write strobe held for exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge ref_clk_i);
		req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: dat};
		@(posedge ref_clk_i);
		req_o.wr <= 1'b0;
	endtask
	// read strobe; data is registered by the taking edge, so sample just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(posedge ref_clk_i);
		req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge ref_clk_i);
		req_o.rd <= 1'b0;
		#1 dat = rdata_i;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import radio_irq_pkg::*;
	localparam int SETTLE = 4; // short settle count keeps the run brief
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	reg_req_type req;
	radio_event_type ev = '0;
	fifo_event_type fev = '0;
	logic strength = 1'b0;
	logic xtal = 1'b0;
	logic [7:0] rdata;
	logic irq_low;
	logic [7:0] d;
	int num_errors = 0;
	int total_checks = 0;
	radio_event_type evs [6];
	logic [7:0] masks [6];

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	radio_interrupt_status_enable #(.SETTLE_CYCLES(SETTLE)) dut (
		.ref_clk_i(ref_clk),
		.nrst_i(nrst),
		.reg_i(req),
		.radio_ev_i(ev),
		.fifo_ev_i(fev),
		.strength_above_i(strength),
		.xtal_on_i(xtal),
		.rdata_o(rdata),
		.interrupt_request_low_o(irq_low)
	);

	host_model host (
		.ref_clk_i(ref_clk),
		.rdata_i(rdata),
		.req_o(req)
	);

	// --------------------
	// compare and stimulus helpers
	// --------------------
	task automatic chk_data(input logic [7:0] exp, input logic [7:0] act);
		total_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("[FAIL] %0t read %h expected %h", $time, act, exp);
		end
	endtask
	task automatic chk_irq(input logic exp);
		total_checks++;
		if (irq_low !== exp) begin
			num_errors++;
			$display("[FAIL] %0t request pin %b expected %b", $time, irq_low, exp);
		end
	endtask
	// read a register and compare in one step
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk_data(exp, d);
	endtask
	// one-cycle event pulse; returns just after the taking edge
	task automatic pulse(input radio_event_type e);
		@(posedge ref_clk);
		ev <= e;
		@(posedge ref_clk);
		ev <= '0;
		#1;
	endtask
	// an enable write reaches the pin on the same edge that it lands
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic final_report();
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog: the sequence needs a few hundred cycles at most
	initial begin
		#50000;
		num_errors++;
		final_report();
	end

	// --------------------
	// main sequence
	// --------------------
	initial begin
		evs = '{'{sync_found: 1'b1, default: 1'b0}, '{preamble_found: 1'b1, default: 1'b0},
			'{preamble_missing: 1'b1, default: 1'b0}, '{wakeup_expired: 1'b1, default: 1'b0},
			'{battery_low: 1'b1, default: 1'b0}, '{power_on_event: 1'b1, default: 1'b0}};
		masks = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01};
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		chk_irq(1'b1);
		// enable registers read back; status two refuses writes, unmapped reads zero
		host.wr(8'h05, 8'hA5);
		rdchk(8'h05, 8'hA5);
		host.wr(8'h06, 8'h5A);
		rdchk(8'h06, 8'h5A);
		host.wr(8'h04, 8'hFF);
		rdchk(8'h04, 8'h00);
		rdchk(8'h1F, 8'h00);
		host.wr(8'h05, 8'h00);
		// six event types (not strength or ready) enabled alone: latch, request, read clears
		for (int i = 0; i < 6; i++) begin
			host.wr(8'h06, masks[i]);
			pulse(evs[i]);
			chk_irq(1'b0);
			rdchk(8'h04, masks[i]);
			chk_irq(1'b1);
			rdchk(8'h04, 8'h00);
		end
		// disabled bits behave as plain status
		host.wr(8'h06, 8'h00);
		pulse('{sync_found: 1'b1, default: 1'b0});
		rdchk(8'h04, 8'h80);
		rdchk(8'h04, 8'h80);
		pulse('{packet_done: 1'b1, default: 1'b0});
		rdchk(8'h04, 8'h00);
		pulse('{preamble_found: 1'b1, default: 1'b0});
		rdchk(8'h04, 8'h40);
		pulse('{sync_timeout: 1'b1, default: 1'b0});
		rdchk(8'h04, 8'h00);
		pulse('{preamble_missing: 1'b1, default: 1'b0});
		rdchk(8'h04, 8'h00);
		@(posedge ref_clk);
		strength <= 1'b1;
		rdchk(8'h04, 8'h10);
		rdchk(8'h04, 8'h10);
		// enabled strength holds its set bit; a read clears it while the level stays
		host.wr(8'h06, 8'h10);
		settle();
		chk_irq(1'b0);
		rdchk(8'h04, 8'h10);
		rdchk(8'h04, 8'h00);
		host.wr(8'h06, 8'h00);
		rdchk(8'h04, 8'h10);
		@(posedge ref_clk);
		strength <= 1'b0;
		rdchk(8'h04, 8'h00);
		// ready only after the settle count, gone when back to idle
		@(posedge ref_clk);
		xtal <= 1'b1;
		rdchk(8'h04, 8'h00);
		repeat (SETTLE) @(posedge ref_clk);
		rdchk(8'h04, 8'h02);
		@(posedge ref_clk);
		xtal <= 1'b0;
		rdchk(8'h04, 8'h00);
		// low battery saved while masked, requests once enabled
		pulse('{battery_low: 1'b1, default: 1'b0});
		chk_irq(1'b1);
		host.wr(8'h06, 8'h04);
		settle();
		chk_irq(1'b0);
		rdchk(8'h04, 8'h04);
		rdchk(8'h04, 8'h00);
		// both status registers feed the one request pin
		host.wr(8'h05, 8'h01);
		host.wr(8'h06, 8'h80);
		@(posedge ref_clk);
		fev.set <= 8'h81;
		ev <= '{sync_found: 1'b1, default: 1'b0};
		@(posedge ref_clk);
		fev.set <= 8'h00;
		ev <= '0;
		#1 chk_irq(1'b0);
		rdchk(8'h04, 8'h80);
		chk_irq(1'b0);
		rdchk(8'h03, 8'h81);
		chk_irq(1'b1);
		rdchk(8'h03, 8'h80);
		// a masked status one bit follows its hardware clear
		@(posedge ref_clk);
		fev.clr <= 8'h80;
		@(posedge ref_clk);
		fev.clr <= 8'h00;
		rdchk(8'h03, 8'h00);
		final_report();
	end
endmodule
